// >>> design/async_ext_memory_port.sv
// asynchronous external memory port with shared capture, flag and pwm pins
module async_ext_memory_port (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // core request side
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input wire logic [ext_mem_pkg::ADDR_W-1:0] i_req_addr,
   input wire logic [ext_mem_pkg::DATA_W-1:0] i_req_wdata,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic [ext_mem_pkg::DATA_W-1:0] o_rsp_rdata,
   // pin usage controls
   input wire ext_mem_pkg::pin_mode_t i_addr_mode,
   input wire ext_mem_pkg::pin_mode_t i_data_mode,
   input wire logic i_mode_load,
   input wire logic i_parallel_capture_control,
   input wire logic [ext_mem_pkg::PWM_N-1:0] i_pwm,
   input wire logic [ext_mem_pkg::FLAG_N-1:0] i_flag_out,
   input wire logic [ext_mem_pkg::FLAG_N-1:0] i_flag_oe,
   output logic [ext_mem_pkg::FLAG_N-1:0] o_flag_in,
   output logic o_capture_valid,
   output logic [ext_mem_pkg::ADDR_W-1:0] o_capture_data,
   output ext_mem_pkg::pin_mode_t o_addr_mode,
   output ext_mem_pkg::pin_mode_t o_data_mode,
   // pins
   output logic [ext_mem_pkg::ADDR_W-1:0] o_ext_address_bus,
   output logic [ext_mem_pkg::ADDR_W-1:0] o_ext_address_bus_oe,
   input wire logic [ext_mem_pkg::ADDR_W-1:0] i_ext_address_bus,
   output logic [ext_mem_pkg::DATA_W-1:0] o_ext_data_bus,
   output logic [ext_mem_pkg::DATA_W-1:0] o_ext_data_bus_oe,
   input wire logic [ext_mem_pkg::DATA_W-1:0] i_ext_data_bus,
   input wire logic i_ext_access_acknowledge,
   output logic o_ext_read_strobe_n,
   output logic o_ext_write_strobe_n
);
   import ext_mem_pkg::*;

   access_state_t state;
   access_state_t next_state;
   logic [3:0] cnt;
   logic is_write;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   pin_mode_t addr_mode;
   pin_mode_t data_mode;
   logic mem_active;

   // cycle count helper used by both setup and strobe phases
   function automatic logic [3:0] phase_len(input int cycles);
      phase_len = (cycles < 1) ? CNT_ONE : 4'(cycles);
   endfunction : phase_len

   // pin usage held in flops so reset always lands in memory mode
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         addr_mode <= PINS_MEMORY;
         data_mode <= PINS_MEMORY;
      end else if (i_mode_load && state == ST_IDLE) begin
         // switching mid access would tear the bus, so wait for idle
         addr_mode <= i_addr_mode;
         data_mode <= i_data_mode;
      end
   end
   assign o_addr_mode = addr_mode;
   assign o_data_mode = data_mode;
   assign mem_active = (addr_mode == PINS_MEMORY) && (data_mode == PINS_MEMORY);

   // access sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (i_req_valid && mem_active) begin
               next_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (cnt == CNT_ONE) begin
               next_state = ST_STROBE;
            end
         end
         ST_STROBE: begin
            // minimum width elapsed and acknowledge high ends the access
            if (cnt == CNT_ONE && i_ext_access_acknowledge) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // phase counter
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         cnt <= '0;
      end else if (state == ST_IDLE && next_state == ST_SETUP) begin
         cnt <= phase_len(SETUP_CYC);
      end else if (state == ST_SETUP && next_state == ST_STROBE) begin
         cnt <= phase_len(STROBE_CYC);
      end else if (cnt > CNT_ONE) begin
         cnt <= cnt - CNT_ONE;
      end
   end

   // request capture
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         addr <= ADDR_RESET;
         wdata <= DATA_RESET;
         is_write <= 1'b0;
      end else if (state == ST_IDLE && next_state == ST_SETUP) begin
         addr <= i_req_addr;
         wdata <= i_req_wdata;
         is_write <= i_req_write;
      end
   end
   assign o_req_ready = (state == ST_IDLE) && mem_active;

   // strobes from flops; only one kind per access, high outside strobe phase
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_ext_read_strobe_n <= 1'b1;
         o_ext_write_strobe_n <= 1'b1;
      end else begin
         o_ext_read_strobe_n <= !(next_state == ST_STROBE && !is_write);
         o_ext_write_strobe_n <= !(next_state == ST_STROBE && is_write);
      end
   end

   // read data taken as the strobe ends
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_rsp_valid <= 1'b0;
         o_rsp_rdata <= DATA_RESET;
      end else begin
         o_rsp_valid <= (state == ST_STROBE) && (next_state == ST_DONE);
         if (state == ST_STROBE && next_state == ST_DONE && !is_write) begin
            o_rsp_rdata <= i_ext_data_bus;
         end
      end
   end

   // parallel capture of address pins, channel 0
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_capture_valid <= 1'b0;
         o_capture_data <= ADDR_RESET;
      end else begin
         o_capture_valid <= i_parallel_capture_control && addr_mode == PINS_CAPTURE;
         if (i_parallel_capture_control && addr_mode == PINS_CAPTURE) begin
            o_capture_data <= i_ext_address_bus;
         end
      end
   end

   // flag inputs come from the low data pins only in flag mode
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_flag_in <= '0;
      end else if (data_mode == PINS_FLAG) begin
         o_flag_in <= i_ext_data_bus[FLAG_N-1:0];
      end
   end

   ext_pin_mux u_mux (
      .i_addr_mode(addr_mode),
      .i_data_mode(data_mode),
      .i_mem_addr(addr),
      .i_mem_addr_oe(state != ST_IDLE),
      .i_mem_data(wdata),
      .i_mem_data_oe(is_write && state != ST_IDLE),
      .i_pwm(i_pwm),
      .i_flag_out(i_flag_out),
      .i_flag_oe(i_flag_oe),
      .o_addr(o_ext_address_bus),
      .o_addr_oe(o_ext_address_bus_oe),
      .o_data(o_ext_data_bus),
      .o_data_oe(o_ext_data_bus_oe)
   );

   // named sequences for the access steps
   sequence s_start;
      state == ST_IDLE && next_state == ST_SETUP;
   endsequence
   sequence s_strobe_low;
      !o_ext_read_strobe_n || !o_ext_write_strobe_n;
   endsequence

   a_strobe_exclusive: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      !(!o_ext_read_strobe_n && !o_ext_write_strobe_n))
      else $error("read and write strobes low together");
   a_idle_strobes_high: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      $past(state) == ST_IDLE && state == ST_IDLE |-> o_ext_read_strobe_n && o_ext_write_strobe_n)
      else $error("strobe low while idle");
   a_ack_holds_access: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      state == ST_STROBE && !i_ext_access_acknowledge |=> state == ST_STROBE)
      else $error("access completed while acknowledge low");
   a_read_strobe_seen: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      s_start ##0 !i_req_write |-> ##[1:8] !o_ext_read_strobe_n)
      else $error("read access without read strobe");
   a_write_strobe_seen: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      s_start ##0 i_req_write |-> ##[1:8] !o_ext_write_strobe_n)
      else $error("write access without write strobe");
   a_addr_on_pins: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      s_strobe_low |-> o_ext_address_bus == addr && o_ext_address_bus_oe == '1)
      else $error("address not on pins during strobe");
   // checked the edge after reset is seen, so no history before the first edge is needed
   a_reset_memory_mode: assert property (@(posedge i_sys_clk)
      i_reset |=> addr_mode == PINS_MEMORY && data_mode == PINS_MEMORY)
      else $error("pins not in memory mode after reset");
   a_capture_sample: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      i_parallel_capture_control && addr_mode == PINS_CAPTURE
      |=> o_capture_valid && o_capture_data == $past(i_ext_address_bus))
      else $error("capture did not sample address pins");
   a_capture_released: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      addr_mode == PINS_CAPTURE |-> o_ext_address_bus_oe == '0)
      else $error("address pins driven in capture mode");
   a_data_flag_mode: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      data_mode == PINS_FLAG |-> o_ext_data_bus_oe[FLAG_N-1:0] == i_flag_oe)
      else $error("flag enables not on data pins");
endmodule : async_ext_memory_port

// >>> design/ext_mem_pkg.sv
// constants, modes and states for the asynchronous external memory port
package ext_mem_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 8;
   localparam int FLAG_N = 4;
   localparam int PWM_N = 8;
   // strobe setup and minimum active width in ns, rounded up to core cycles
   localparam int SETUP_NS = 10;
   localparam int STROBE_NS = 20;
   localparam int CLK_PERIOD_NS = 5;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h00_0000;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

   // pin group usage, memory interface mode is the reset value
   typedef enum logic [1:0] {
      PINS_MEMORY = 2'h0,
      PINS_CAPTURE = 2'h1,
      PINS_PWM = 2'h2,
      PINS_FLAG = 2'h3
   } pin_mode_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_SETUP = 4'h2,
      ST_STROBE = 4'h4,
      ST_DONE = 4'h8
   } access_state_t;
endpackage : ext_mem_pkg

// >>> design/ext_pin_mux.sv
// output selection and enable for the shared address and data pins
module ext_pin_mux (
   input wire ext_mem_pkg::pin_mode_t i_addr_mode,
   input wire ext_mem_pkg::pin_mode_t i_data_mode,
   input wire logic [ext_mem_pkg::ADDR_W-1:0] i_mem_addr,
   input wire logic i_mem_addr_oe,
   input wire logic [ext_mem_pkg::DATA_W-1:0] i_mem_data,
   input wire logic i_mem_data_oe,
   input wire logic [ext_mem_pkg::PWM_N-1:0] i_pwm,
   input wire logic [ext_mem_pkg::FLAG_N-1:0] i_flag_out,
   input wire logic [ext_mem_pkg::FLAG_N-1:0] i_flag_oe,
   output logic [ext_mem_pkg::ADDR_W-1:0] o_addr,
   output logic [ext_mem_pkg::ADDR_W-1:0] o_addr_oe,
   output logic [ext_mem_pkg::DATA_W-1:0] o_data,
   output logic [ext_mem_pkg::DATA_W-1:0] o_data_oe
);
   import ext_mem_pkg::*;

   // address pins: memory address, pwm on the low byte, or released for capture
   always_comb begin
      o_addr = '0;
      o_addr_oe = '0;
      unique case (i_addr_mode)
         PINS_MEMORY: begin
            o_addr = i_mem_addr;
            o_addr_oe = {ADDR_W{i_mem_addr_oe}};
         end
         PINS_PWM: begin
            o_addr[PWM_N-1:0] = i_pwm;
            o_addr_oe[PWM_N-1:0] = '1;
         end
         default: begin
            o_addr = '0; // capture input or unused: pins stay released
         end
      endcase
   end

   // data pins: memory data, capture input, flags in the low nibble, or pwm
   always_comb begin
      o_data = '0;
      o_data_oe = '0;
      unique case (i_data_mode)
         PINS_MEMORY: begin
            o_data = i_mem_data;
            o_data_oe = {DATA_W{i_mem_data_oe}};
         end
         PINS_FLAG: begin
            o_data[FLAG_N-1:0] = i_flag_out;
            o_data_oe[FLAG_N-1:0] = i_flag_oe;
         end
         PINS_PWM: begin
            o_data = i_pwm;
            o_data_oe = '1;
         end
         default: begin
            o_data = '0; // capture: input only
         end
      endcase
   end
endmodule : ext_pin_mux

// >>> tb/mem_partner.sv
// behavioural asynchronous memory on the far side of the port
module mem_partner (
   input wire logic i_sys_clk,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [23:0] i_addr,
   input wire logic [7:0] i_data,
   input wire logic [7:0] i_wait,
   output logic o_ack,
   output logic [7:0] o_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:255];
   logic [7:0] wcnt = 8'h00;
   logic [7:0] last = 8'h00;
   // preset contents so an unwritten byte reads back its own index
   initial begin
      for (int k = 0; k < 256; k++) begin
         mem[k] = 8'(k);
      end
   end
   // count strobe cycles, latch write data while the write strobe is low
   always @(posedge i_sys_clk) begin
      wcnt <= (i_rd_n && i_wr_n) ? 8'h00 : wcnt + 8'h01;
      if (!i_wr_n) begin
         mem[i_addr[7:0]] <= i_data;
      end
      if (!i_rd_n) begin
         last <= mem[i_addr[7:0]];
      end
   end
   // hold acknowledge low for i_wait strobe cycles
   assign o_ack = !(!(i_rd_n && i_wr_n) && wcnt < i_wait);
   // released bus shows the inverse of the last byte, not a stale copy
   assign o_data = i_rd_n ? ~last : mem[i_addr[7:0]];
endmodule : mem_partner

// >>> tb/tb_top.sv
// self-checking bench for the asynchronous external memory port
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ext_mem_pkg::*;
   logic sys_clk = 0, reset = 1, req_valid = 0, req_write = 0, mode_load = 0, cap_ctl = 0;
   logic [23:0] req_addr = '0, tb_addr = '0, addr_o, addr_oe, addr_pin, cap_data;
   logic [7:0] req_wdata = '0, pwm = '0, wt = '0, data_o, data_oe, data_pin, mem_d, rdata;
   logic [3:0] flag_out = '0, flag_oe = '0, flag_in;
   pin_mode_t addr_mode = PINS_MEMORY, data_mode = PINS_MEMORY, am_o, dm_o;
   logic ready, rsp, cap_v, rd_n, wr_n, ack;
   int bad_count = 0, comparisons = 0, cyc = 0;
   // pin levels resolved from both drivers
   assign addr_pin = (addr_o & addr_oe) | (tb_addr & ~addr_oe);
   assign data_pin = (data_o & data_oe) | (mem_d & ~data_oe);
   async_ext_memory_port async_ext_memory_port_inst (.i_sys_clk(sys_clk), .i_reset(reset),
      .i_req_valid(req_valid), .i_req_write(req_write), .i_req_addr(req_addr),
      .i_req_wdata(req_wdata), .o_req_ready(ready), .o_rsp_valid(rsp), .o_rsp_rdata(rdata),
      .i_addr_mode(addr_mode), .i_data_mode(data_mode), .i_mode_load(mode_load),
      .i_parallel_capture_control(cap_ctl), .i_pwm(pwm), .i_flag_out(flag_out),
      .i_flag_oe(flag_oe), .o_flag_in(flag_in), .o_capture_valid(cap_v),
      .o_capture_data(cap_data), .o_addr_mode(am_o), .o_data_mode(dm_o),
      .o_ext_address_bus(addr_o), .o_ext_address_bus_oe(addr_oe), .i_ext_address_bus(addr_pin),
      .o_ext_data_bus(data_o), .o_ext_data_bus_oe(data_oe), .i_ext_data_bus(data_pin),
      .i_ext_access_acknowledge(ack), .o_ext_read_strobe_n(rd_n), .o_ext_write_strobe_n(wr_n));
   mem_partner mem_partner_inst (.i_sys_clk(sys_clk), .i_rd_n(rd_n), .i_wr_n(wr_n),
      .i_addr(addr_pin), .i_data(data_pin), .i_wait(wt), .o_ack(ack), .o_data(mem_d));
   // 200 MHz clock
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic end_sim();
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   // hang guard, far above the fewer than a hundred cycles the tests need
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         end_sim();
      end
   end
   // wide enough for the strobe, enable and data concatenations checked after reset
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // modes are only taken while idle, so allow a couple of cycles to settle
   task automatic set_modes(input pin_mode_t am, input pin_mode_t dm);
      @(posedge sys_clk);
      addr_mode <= am;
      data_mode <= dm;
      mode_load <= 1'b1;
      @(posedge sys_clk);
      mode_load <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : set_modes
   // one access, judging strobes, address and wait handling on the way
   task automatic access(input logic w, input logic [23:0] a, input logic [7:0] d,
                         input logic [7:0] waits, input logic [7:0] exp);
      int n;
      int lo;
      int falls;
      logic bad;
      logic prev;
      logic own;
      n = 0;
      lo = 0;
      falls = 0;
      bad = 0;
      prev = 1;
      @(posedge sys_clk);
      wt <= waits;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      #1;
      while (ready !== 1'b1 && n < 50) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      @(posedge sys_clk);
      req_valid <= 1'b0;
      #1;
      while (rsp !== 1'b1 && n < 200) begin
         own = w ? wr_n : rd_n;
         if (own === 1'b0) begin
            lo++;
            falls += prev;
            bad |= (addr_o !== a) || (addr_oe !== 24'hFF_FFFF);
         end
         bad |= (w ? rd_n : wr_n) !== 1'b1;
         prev = (own === 1'b1);
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk("response", rsp, 1'b1);
      chk("address_and_other_strobe", bad, 1'b0);
      chk("strobe_pulses", falls, 1);
      chk("strobe_held_for_waits", lo >= STROBE_CYC && lo >= waits, 1'b1);
      chk("strobes_idle", {rd_n, wr_n}, 2'h3);
      if (!w) begin
         chk("read_data", rdata, exp);
      end
   endtask : access
   // capture channel samples the address pins
   task automatic capture_test();
      tb_addr <= 24'hC0_FFEE;
      cap_ctl <= 1'b1;
      set_modes(PINS_CAPTURE, PINS_CAPTURE);
      chk("capture_valid", cap_v, 1'b1);
      chk("capture_data", cap_data, 24'hC0_FFEE);
      chk("address_released", addr_oe, 24'h00_0000);
      chk("busy_outside_memory", ready, 1'b0);
      cap_ctl <= 1'b0;
   endtask : capture_test
   // pwm levels on both pin groups, then flags on the data pins
   task automatic pwm_flag_test();
      pwm <= 8'h5A;
      set_modes(PINS_PWM, PINS_PWM);
      chk("pwm_on_address", addr_pin[7:0], 8'h5A);
      chk("pwm_on_data", {data_oe, data_pin}, 16'hFF5A);
      flag_out <= 4'h9;
      flag_oe <= 4'hF;
      set_modes(PINS_FLAG, PINS_FLAG);
      chk("address_released_in_flag", addr_oe, 24'h00_0000);
      chk("flag_pins", data_pin[3:0], 4'h9);
      chk("flag_in", flag_in, 4'h9);
      set_modes(PINS_MEMORY, PINS_MEMORY);
      chk("ready_back_in_memory", ready, 1'b1);
   endtask : pwm_flag_test
   // reset, then every scenario in turn
   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("modes_after_reset", {am_o, dm_o}, {PINS_MEMORY, PINS_MEMORY});
      chk("pins_after_reset", {rd_n, wr_n, addr_oe, data_oe}, 34'h3_0000_0000);
      access(1'b1, 24'h12_34A5, 8'h3C, 8'h00, 8'h00);
      access(1'b0, 24'h12_34A5, 8'h00, 8'h09, 8'h3C);
      access(1'b0, 24'hFF_FF07, 8'h00, 8'h00, 8'h07);
      capture_test();
      pwm_flag_test();
      access(1'b1, 24'h00_0011, 8'hC3, 8'h0C, 8'h00);
      access(1'b0, 24'h00_0011, 8'h00, 8'h00, 8'hC3);
      end_sim();
   end
endmodule : tb_top
